/* File: pkg/spibsd_defines.vh */
// Register map, field positions and reset values of the serial port block
`ifndef SPIBSD_DEFINES_VH
`define SPIBSD_DEFINES_VH
`define SPIBSD_ADDR_CTRL1 12'h000
`define SPIBSD_ADDR_CTRL2 12'h004
`define SPIBSD_ADDR_BAUD 12'h008
`define SPIBSD_ADDR_STATUS 12'h00C
`define SPIBSD_ADDR_DATA 12'h010
`define SPIBSD_ADDR_IRQ_MASK 12'h014
`define SPIBSD_ADDR_IRQ_STAT 12'h018
`define SPIBSD_CTRL1_ENABLE 6
`define SPIBSD_CTRL1_MASTER 4
`define SPIBSD_CTRL2_MODE_FAULT_FLAG_EN 4
`define SPIBSD_ST_RXFULL 7
`define SPIBSD_ST_TXEMPTY 5
`define SPIBSD_ST_MODE_FAULT_FLAG 4
`define SPIBSD_IRQ_RX 0
`define SPIBSD_IRQ_TX 1
`define SPIBSD_IRQ_MODE_FAULT_FLAG 2
`define SPIBSD_CTRL1_RESET 8'h00
`define SPIBSD_CTRL2_RESET 8'h00
`define SPIBSD_BAUD_RESET 8'h00
`define SPIBSD_DATA_RESET 8'h00
`define SPIBSD_MASK_RESET 3'h0
`define SPIBSD_BITS_PER_XFER 4'h8
`endif

/* File: src/spibsd_top.v */
// Serial port with baud divider, status flags, data path and APB slave
`include "spibsd_defines.vh"
`default_nettype none

module spibsd_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe,
    input wire ss_n_in
);

    // ****************************************
    // Helpers
    // ****************************************
    // Half period of sck in pclk cycles: divisor / 2
    function [10:0] spibsd_half_div;
        input [2:0] pre;
        input [2:0] sel;
        begin
            spibsd_half_div = ({8'h00, pre} + 11'h001) << sel;
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] ctrl1_q;
    reg [7:0] ctrl2_q;
    reg [7:0] baud_q;
    reg [7:0] rx_data_q;
    reg [7:0] tx_data_q;
    reg [2:0] irq_mask_q;
    reg [2:0] irq_stat_q;
    reg rx_full_q;
    reg tx_empty_q;
    reg mode_fault_flag_q;
    reg rx_seen_q;
    reg tx_seen_q;
    reg mode_fault_flag_seen_q;

    // Pin synchronisers: 3 stages, change taken when stages 2 and 3 agree
    reg [2:0] sck_sync_q;
    reg [2:0] mosi_sync_q;
    reg [2:0] miso_sync_q;
    reg [2:0] ss_sync_q;
    reg sck_f_q;
    reg mosi_f_q;
    reg miso_f_q;
    reg ss_f_q;

    // Shifter
    localparam ST_IDLE = 2'd0;
    localparam ST_LEAD = 2'd1;
    localparam ST_TRAIL = 2'd2;
    reg [1:0] state_q;
    reg [7:0] shift_q;
    reg [3:0] bit_cnt_q;
    reg [10:0] div_cnt_q;
    reg in_bit_q;
    reg sck_prev_q;

    wire wr_acc = psel & penable & pwrite;
    wire rd_acc = psel & penable & ~pwrite;
    wire enabled = ctrl1_q[`SPIBSD_CTRL1_ENABLE];
    wire is_master = ctrl1_q[`SPIBSD_CTRL1_MASTER];
    wire mode_fault_flag_en = ctrl2_q[`SPIBSD_CTRL2_MODE_FAULT_FLAG_EN];
    wire [10:0] half_div = spibsd_half_div(baud_q[6:4], baud_q[2:0]);
    wire wr_ctrl1 = wr_acc && (paddr == `SPIBSD_ADDR_CTRL1);
    wire rd_stat = rd_acc && (paddr == `SPIBSD_ADDR_STATUS);
    wire rd_data = rd_acc && (paddr == `SPIBSD_ADDR_DATA);
    wire wr_data = wr_acc && (paddr == `SPIBSD_ADDR_DATA);
    wire ss_fault = enabled & is_master & mode_fault_flag_en & ~ss_f_q;
    wire slave_sel = enabled & ~is_master & ~ss_f_q;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign irq = |(irq_stat_q & irq_mask_q);

    // ****************************************
    // Pin input filtering
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_sync_q <= 3'h0;
            mosi_sync_q <= 3'h0;
            miso_sync_q <= 3'h0;
            ss_sync_q <= 3'h7;
            sck_f_q <= 1'b0;
            mosi_f_q <= 1'b0;
            miso_f_q <= 1'b0;
            ss_f_q <= 1'b1;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], sck_in};
            mosi_sync_q <= {mosi_sync_q[1:0], mosi_in};
            miso_sync_q <= {miso_sync_q[1:0], miso_in};
            ss_sync_q <= {ss_sync_q[1:0], ss_n_in};
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_f_q <= sck_sync_q[2];
            end
            if (mosi_sync_q[1] == mosi_sync_q[2]) begin
                mosi_f_q <= mosi_sync_q[2];
            end
            if (miso_sync_q[1] == miso_sync_q[2]) begin
                miso_f_q <= miso_sync_q[2];
            end
            if (ss_sync_q[1] == ss_sync_q[2]) begin
                ss_f_q <= ss_sync_q[2];
            end
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    reg xfer_done;
    reg tx_take;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            shift_q <= `SPIBSD_DATA_RESET;
            bit_cnt_q <= 4'h0;
            div_cnt_q <= 11'h000;
            in_bit_q <= 1'b0;
            sck_prev_q <= 1'b0;
            xfer_done <= 1'b0;
            tx_take <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            tx_take <= 1'b0;
            sck_prev_q <= sck_f_q;
            if (!enabled || ss_fault) begin
                state_q <= ST_IDLE;
                bit_cnt_q <= 4'h0;
            end else if (is_master) begin
                case (state_q)
                    ST_IDLE: begin
                        if (!tx_empty_q && !tx_take) begin
                            shift_q <= tx_data_q;
                            tx_take <= 1'b1;
                            bit_cnt_q <= 4'h0;
                            div_cnt_q <= 11'h001;
                            state_q <= ST_LEAD;
                        end
                    end
                    ST_LEAD: begin
                        if (div_cnt_q >= half_div) begin
                            div_cnt_q <= 11'h001;
                            state_q <= ST_TRAIL;
                        end else begin
                            div_cnt_q <= div_cnt_q + 11'h001;
                        end
                    end
                    ST_TRAIL: begin
                        if (div_cnt_q >= half_div) begin
                            div_cnt_q <= 11'h001;
                            // Late miso sample absorbs the pin filter delay
                            shift_q <= {shift_q[6:0], miso_f_q};
                            if (bit_cnt_q == `SPIBSD_BITS_PER_XFER - 4'h1) begin
                                xfer_done <= 1'b1;
                                state_q <= ST_IDLE;
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                                state_q <= ST_LEAD;
                            end
                        end else begin
                            div_cnt_q <= div_cnt_q + 11'h001;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end else if (!slave_sel) begin
                state_q <= ST_IDLE;
                bit_cnt_q <= 4'h0;
                if (!tx_empty_q && !tx_take) begin
                    shift_q <= tx_data_q;
                    tx_take <= 1'b1;
                end
            end else begin
                // Slave: sample on rising sck, shift on falling
                state_q <= ST_LEAD;
                if (sck_f_q && !sck_prev_q) begin
                    in_bit_q <= mosi_f_q;
                end else if (!sck_f_q && sck_prev_q) begin
                    shift_q <= {shift_q[6:0], in_bit_q};
                    if (bit_cnt_q == `SPIBSD_BITS_PER_XFER - 4'h1) begin
                        bit_cnt_q <= 4'h0;
                        xfer_done <= 1'b1;
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_out <= (state_q == ST_TRAIL);
            sck_oe <= enabled & is_master & ~ss_fault;
            mosi_oe <= enabled & is_master & ~ss_fault;
            mosi_out <= shift_q[7];
            miso_oe <= slave_sel & ~mode_fault_flag_q;
            miso_out <= shift_q[7];
        end
    end

    // ****************************************
    // Status flags and data buffers
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_q <= `SPIBSD_DATA_RESET;
            tx_data_q <= `SPIBSD_DATA_RESET;
            rx_full_q <= 1'b0;
            tx_empty_q <= 1'b1;
            mode_fault_flag_q <= 1'b0;
            rx_seen_q <= 1'b0;
            tx_seen_q <= 1'b0;
            mode_fault_flag_seen_q <= 1'b0;
        end else begin
            if (rd_stat) begin
                // Arm from the flags the reader was actually shown
                rx_seen_q <= prdata[`SPIBSD_ST_RXFULL];
                tx_seen_q <= prdata[`SPIBSD_ST_TXEMPTY];
                mode_fault_flag_seen_q <= prdata[`SPIBSD_ST_MODE_FAULT_FLAG];
            end
            // Receive: later bytes lost while flag unserviced
            if (xfer_done && !rx_full_q) begin
                rx_data_q <= shift_q;
                rx_full_q <= 1'b1;
            end else if (rd_data && rx_seen_q) begin
                rx_full_q <= 1'b0;
                rx_seen_q <= 1'b0;
            end
            // Transmit queue
            if (wr_data && tx_seen_q && tx_empty_q) begin
                tx_data_q <= pwdata[7:0];
                tx_empty_q <= 1'b0;
                tx_seen_q <= 1'b0;
            end else if (tx_take) begin
                tx_empty_q <= 1'b1;
            end else if (wr_data) begin
                tx_seen_q <= 1'b0;
            end
            if (ss_fault) begin
                mode_fault_flag_q <= 1'b1;
            end else if (wr_ctrl1 && mode_fault_flag_seen_q) begin
                mode_fault_flag_q <= 1'b0;
                mode_fault_flag_seen_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control registers and interrupts
    // ****************************************
    wire [2:0] irq_ev = {ss_fault, tx_take, xfer_done & ~rx_full_q};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= `SPIBSD_CTRL1_RESET;
            ctrl2_q <= `SPIBSD_CTRL2_RESET;
            baud_q <= `SPIBSD_BAUD_RESET;
            irq_mask_q <= `SPIBSD_MASK_RESET;
            irq_stat_q <= 3'h0;
        end else begin
            if (wr_ctrl1) begin
                ctrl1_q <= pwdata[7:0];
            end else if (ss_fault) begin
                ctrl1_q[`SPIBSD_CTRL1_MASTER] <= 1'b0;
            end
            if (wr_acc && paddr == `SPIBSD_ADDR_CTRL2) begin
                ctrl2_q <= pwdata[7:0];
            end
            if (wr_acc && paddr == `SPIBSD_ADDR_BAUD) begin
                baud_q <= pwdata[7:0] & 8'h77;
            end
            if (wr_acc && paddr == `SPIBSD_ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
            if (wr_acc && paddr == `SPIBSD_ADDR_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `SPIBSD_ADDR_CTRL1) begin
                prdata <= {24'h000000, ctrl1_q};
            end else if (paddr == `SPIBSD_ADDR_CTRL2) begin
                prdata <= {24'h000000, ctrl2_q};
            end else if (paddr == `SPIBSD_ADDR_BAUD) begin
                prdata <= {24'h000000, baud_q};
            end else if (paddr == `SPIBSD_ADDR_STATUS) begin
                prdata <= {24'h000000, rx_full_q, 1'b0, tx_empty_q, mode_fault_flag_q,
                           4'h0};
            end else if (paddr == `SPIBSD_ADDR_DATA) begin
                prdata <= {24'h000000, rx_data_q};
            end else if (paddr == `SPIBSD_ADDR_IRQ_MASK) begin
                prdata <= {29'h00000000, irq_mask_q};
            end else if (paddr == `SPIBSD_ADDR_IRQ_STAT) begin
                prdata <= {29'h00000000, irq_stat_q};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // spibsd_top
`default_nettype wire

/* File: verification/spi_baud_status_data_path_test.sv */
// Self-checking bench for the serial port block
`include "spibsd_defines.vh"
`default_nettype none
module spi_baud_status_data_path_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_ST = `SPIBSD_ADDR_STATUS;
    localparam logic [11:0] A_DAT = `SPIBSD_ADDR_DATA;
    localparam logic [11:0] A_C1 = `SPIBSD_ADDR_CTRL1;
    logic pclk, presetn, psel, penable, pwrite, sck_in, mosi_in, ss_n_in;
    logic pready, pslverr, irq, sck_out, sck_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe, miso;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] reply, rx_byte, rx_count;
    int failures, comparisons;
    spibsd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .sck_in, .sck_out,
        .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in(miso), .miso_out,
        .miso_oe, .ss_n_in);
    spibsd_partner u_peer (.presetn, .sck(sck_out), .mosi(mosi_out),
        .reply, .miso, .rx_byte, .rx_count);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ****************
    // Shared tasks
    // ****************
    task end_of_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) chk(32'h0, 32'h1);
        if (n >= 16) end_of_test();
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_rx(input logic [7:0] c);
        int n;
        n = 0;
        while (rx_count !== c && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(rx_count), 32'(c));
        if (n >= 40000) end_of_test();
    endtask
    task high_len(output int n);
        n = 0;
        while (sck_out !== 1'b1 && n < 5000) begin
            @(negedge pclk);
            n++;
        end
        n = 0;
        while (sck_out === 1'b1 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
    endtask
    task arm_tx;
        int n;
        n = 0;
        do begin
            rd(A_ST);
            n++;
        end while (r[`SPIBSD_ST_TXEMPTY] !== 1'b1 && n < 8);
        chk(32'(r[`SPIBSD_ST_TXEMPTY]), 32'h1);
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_discard;
        wr(A_DAT, 32'hEE);
        repeat (200) @(posedge pclk);
        chk(32'(rx_count), 32'h0);
        rd(A_ST);
        chk(r, 32'h20);
        wr(A_ST, 32'hFF);
        rd(A_ST);
        chk(r, 32'h20);
        rd(A_DAT);
        chk(r, 32'h0);
        rd(12'hFFC);
        chk(r, 32'h0);
    endtask
    task t_stream;
        rd(A_ST);
        wr(A_DAT, 32'hA5);
        reply <= 8'hC3;
        arm_tx();
        wr(A_DAT, 32'h5A);
        rd(A_ST);
        chk(r, 32'h0);
        wait_rx(8'h1);
        chk(32'(rx_byte), 32'hA5);
        wait_rx(8'h2);
        chk(32'(rx_byte), 32'h5A);
        rd(A_DAT);
        chk(r, 32'h3C);
        rd(A_ST);
        chk(r, 32'hA0);
        wr(`SPIBSD_ADDR_IRQ_MASK, 32'h1);
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        wr(`SPIBSD_ADDR_IRQ_MASK, 32'h0);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        wr(`SPIBSD_ADDR_IRQ_STAT, 32'h1);
        wr(`SPIBSD_ADDR_IRQ_MASK, 32'h1);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        rd(A_DAT);
        rd(A_ST);
        chk(r, 32'h20);
    endtask
    task t_baud;
        int n;
        logic [7:0] bd [4];
        int dv [4];
        bd = '{8'h40, 8'h50, 8'h67, 8'h77};
        dv = '{10, 12, 1792, 2048};
        for (int i = 0; i < 4; i++) begin
            wr(`SPIBSD_ADDR_BAUD, 32'(bd[i]));
            rd(A_ST);
            wr(A_DAT, 32'h81);
            high_len(n);
            chk(32'(2 * n), 32'(dv[i]));
            wait_rx(8'(3 + i));
            rd(A_ST);
            rd(A_DAT);
            chk(r, 32'hC3);
        end
    endtask
    task t_fault;
        int n;
        wr(`SPIBSD_ADDR_BAUD, 32'h50);
        rd(A_ST);
        wr(A_DAT, 32'h99);
        high_len(n);
        @(posedge pclk);
        ss_n_in <= 1'b0;
        repeat (12) @(posedge pclk);
        @(negedge pclk);
        chk(32'({sck_oe, mosi_oe, miso_oe}), 32'h0);
        @(posedge pclk);
        ss_n_in <= 1'b1;
        rd(A_C1);
        chk(r, 32'h40);
        rd(`SPIBSD_ADDR_IRQ_STAT);
        chk(r, 32'h7);
        wr(A_C1, 32'h40);
        rd(A_ST);
        chk(r, 32'h30);
        wr(A_C1, 32'h50);
        rd(A_ST);
        chk(r, 32'h20);
        chk(32'(rx_count), 32'h6);
    endtask
    task t_slave;
        logic [7:0] so;
        logic [7:0] si;
        si = 8'h5A;
        so = 8'h00;
        wr(A_C1, 32'h40);
        rd(A_ST);
        wr(A_DAT, 32'h96);
        @(posedge pclk);
        ss_n_in <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi_in <= si[i];
            repeat (7) @(posedge pclk);
            @(negedge pclk);
            so[i] = miso_out;
            @(posedge pclk);
            sck_in <= 1'b1;
            repeat (8) @(posedge pclk);
            sck_in <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk(32'(miso_oe), 32'h1);
        @(posedge pclk);
        ss_n_in <= 1'b1;
        chk(32'(so), 32'h96);
        rd(A_ST);
        chk(r, 32'hA0);
        rd(A_DAT);
        chk(r, 32'h5A);
    endtask
    initial begin
        {psel, penable, pwrite, sck_in, mosi_in} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        ss_n_in = 1'b1;
        reply = 8'h3C;
        failures = 0;
        comparisons = 0;
        presetn = 1'b1;
        #1 presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(A_C1, 32'h50);
        wr(`SPIBSD_ADDR_CTRL2, 32'h10);
        wr(`SPIBSD_ADDR_BAUD, 32'h50);
        t_discard();
        t_stream();
        t_baud();
        t_fault();
        t_slave();
        end_of_test();
    end
endmodule // spi_baud_status_data_path_test
`default_nettype wire

/* File: verification/spibsd_checker.sv */
// Port-level assertion checker for the serial port block
`include "spibsd_defines.vh"
`default_nettype none
module spibsd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Shadow baud and sck high time
    // ****************
    logic [2:0] pre_q;
    logic [2:0] sel_q;
    logic fault_en_q;
    logic [11:0] high_q;
    logic [11:0] half;
    logic rd_st;
    assign half = ({9'h000, pre_q} + 12'h001) << sel_q;
    assign rd_st = psel && penable && !pwrite && paddr == `SPIBSD_ADDR_STATUS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 3'h0;
            sel_q <= 3'h0;
            fault_en_q <= 1'b0;
            high_q <= 12'h000;
        end else begin
            if (psel && penable && pwrite && paddr == `SPIBSD_ADDR_BAUD) begin
                pre_q <= pwdata[6:4];
                sel_q <= pwdata[2:0];
            end
            high_q <= sck_out ? high_q + 12'h001 : 12'h000;
            if (psel && penable && pwrite && paddr == `SPIBSD_ADDR_CTRL2) begin
                fault_en_q <= pwdata[`SPIBSD_CTRL2_MODE_FAULT_FLAG_EN];
            end
        end
    end
    pready_high_a: assert property (pready)
        else $error("pready low");
    no_slverr_a: assert property (!pslverr)
        else $error("pslverr raised");
    status_bits_a: assert property (rd_st |-> (prdata & 32'hFFFFFF4F) == 0)
        else $error("status reserved bits set");
    half_period_a: assert property ($fell(sck_out) && sck_oe |-> high_q == half)
        else $error("sck high time wrong");
    fault_release_a: assert property
        ((fault_en_q && !ss_n_in) [*8] |-> !sck_oe && !mosi_oe)
        else $error("outputs driven after fault");
    read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    master_miso_a: assert property (sck_oe |-> !miso_oe)
        else $error("master drives miso");
    unselected_a: assert property (ss_n_in [*8] |-> !miso_oe)
        else $error("miso driven unselected");
    cover property ($fell(sck_out) && sck_oe);
    cover property (!ss_n_in [*8]);
    cover property (rd_st && prdata[7]);
endmodule // spibsd_checker
bind spibsd_top spibsd_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_out, .sck_oe,
    .mosi_oe, .miso_oe, .ss_n_in);
`default_nettype wire

/* File: verification/spibsd_partner.sv */
// Behavioural serial slave answering the block's master transfers
`default_nettype none
module spibsd_partner (
    input wire logic presetn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Slave shifter, mode 0, msb first
    // ****************
    logic [7:0] sh_q;
    logic [7:0] in_q;
    logic [2:0] bit_q;
    assign miso = sh_q[7];
    always @(posedge sck or negedge presetn) begin
        if (!presetn) begin
            in_q <= 8'h00;
        end else begin
            in_q <= {in_q[6:0], mosi};
        end
    end
    // Clocked only by the block's sck, never faster than half pclk
    always @(negedge sck or negedge presetn) begin
        if (!presetn) begin
            sh_q <= reply;
            bit_q <= 3'h0;
            rx_byte <= 8'h00;
            rx_count <= 8'h00;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
                sh_q <= reply;
                rx_byte <= in_q;
                rx_count <= rx_count + 8'h01;
            end else begin
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end
endmodule // spibsd_partner
`default_nettype wire
